/* temp_report_params.svh */
// Operation
// R1: amplitude mode reports when temperature leaves deadband around last report
// R2: deadband is whole degrees 1 to 50, reset value 1
// R3: integrated mode reports when deviation integral exceeds deadband times 1 s
// R4: periodic reports fire at each period expiry beside change reports
// R5: report period is 0 to 3600 seconds, reset value 0
// R6: a zero period never produces time-triggered reports
// R7: measured temperature is presented in degrees Celsius for display
// R8: cold alarm is 1 while temperature is below cold threshold
// R9: hot alarm is 1 while temperature is above hot threshold
// R10: range violation is 1 while below floor or above ceiling
// R11: no binary control inputs; only three status flags as binary outputs (the code also drives 1-bit report_out and irq_out)
// R12: report mode off, amplitude or integrated; off suppresses every report
// R13: each channel uses its own instance with no shared state
// R14: any report latches reference value and clears the accumulator
`ifndef TEMP_REPORT_PARAMS_SVH
`define TEMP_REPORT_PARAMS_SVH
`define CLK_FREQ_HZ        40000000
`define TICK_PERIOD_S      1
`define TICK_CYCLES        (`CLK_FREQ_HZ * `TICK_PERIOD_S)
`define DEADBAND_MIN       8'h01
`define DEADBAND_MAX       8'h32
`define DEADBAND_RST       8'h01
`define PERIOD_MAX         12'he10
`define PERIOD_RST         12'h000
`define FLOOR_RST          8'h32
`define CEILING_RST        8'h96
`define COLD_RST           8'h32
`define HOT_RST            8'h64
`define TEMP_MIN           8'hce
`define TEMP_MAX           8'h96
`endif

/* temp_report_pkg.sv */
package temp_report_pkg;
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_AMPLITUDE,
        MODE_INTEGRATED
    } report_mode_t;
    typedef logic signed [7:0] temp_t;
endpackage

/* seconds_ticker.sv */
`timescale 1ns/1ps
`include "temp_report_params.svh"
module seconds_ticker
#(
    parameter int CYCLES = `TICK_CYCLES
)
(
    input  wire logic core_clk_in,
    input  wire logic reset_in,
    input  wire logic clk_en_in,
    output logic      tick_out
);
    logic [31:0] count_ff;
    wire         wrap = (count_ff == 32'(CYCLES - 1));
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            count_ff <= 32'h0;
            tick_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            count_ff <= wrap ? 32'h0 : count_ff + 32'h1;
            tick_out <= wrap;
        end
    end
endmodule // seconds_ticker

/* period_timer.sv */
`timescale 1ns/1ps
`include "temp_report_params.svh"
module period_timer
(
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    input  wire logic        clk_en_in,
    input  wire logic        tick_in,
    input  wire logic [11:0] period_in,
    output logic             expire_out
);
    logic [11:0] secs_ff;
    wire         enabled = (period_in != 12'h000); // R6
    wire         reached = enabled && tick_in && (secs_ff + 12'h1 >= period_in);
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            secs_ff    <= 12'h000;
            expire_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            expire_out <= reached; // R4
            if (!enabled || reached)
                secs_ff <= 12'h000;
            else if (tick_in)
                secs_ff <= secs_ff + 12'h1;
        end
    end
endmodule // period_timer

/* temperature_channel_block.sv */
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "temp_report_params.svh"
module temperature_channel_block
    import temp_report_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    input  wire logic        clk_en_in,
    input  wire logic [7:0]  temp_in,
    input  wire logic        temp_valid_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    output logic             cold_alarm_flag_out, // R11
    output logic             hot_alarm_flag_out,
    output logic             range_violation_flag_out,
    output logic             report_out,
    output logic      [7:0]  report_value_out,
    output logic      [7:0]  display_temp_out,
    output logic             irq_out
);
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] A_MODE     = 8'h00;
    localparam logic [7:0] A_DEADBAND = 8'h04;
    localparam logic [7:0] A_PERIOD   = 8'h08;
    localparam logic [7:0] A_COLD     = 8'h0c;
    localparam logic [7:0] A_HOT      = 8'h10;
    localparam logic [7:0] A_FLOOR    = 8'h14;
    localparam logic [7:0] A_CEILING  = 8'h18;
    localparam logic [7:0] A_TEMP     = 8'h1c;
    localparam logic [7:0] A_REFVAL   = 8'h20;
    localparam logic [7:0] A_STATUS   = 8'h24;
    localparam logic [7:0] A_MASK     = 8'h28;
    localparam logic [7:0] A_IRQ_STAT = 8'h2c;
    localparam logic [7:0] A_IRQ_MASK = 8'h30;

    function automatic logic signed [31:0] sx(input logic [7:0] v);
        // codes from the TEMP_MIN code upward are the negative degrees
        sx = (v >= `TEMP_MIN) ? $signed({24'hffffff, v}) :
                                $signed({24'h000000, v});
    endfunction

    function automatic logic [7:0] clamp8(input logic [7:0] v,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
        if (v < lo)
            clamp8 = lo;
        else if (v > hi)
            clamp8 = hi;
        else
            clamp8 = v;
    endfunction

    function automatic logic [7:0] clamp_temp(input logic [15:0] v);
        logic signed [15:0] s;
        s = signed'(v);
        if (s < 16'(signed'(`TEMP_MIN)))
            clamp_temp = `TEMP_MIN;
        else if (s > signed'(16'(`TEMP_MAX)))
            clamp_temp = `TEMP_MAX;
        else
            clamp_temp = v[7:0];
    endfunction

    // ---------------------------------------------------------------
    // settings
    // ---------------------------------------------------------------
    report_mode_t report_mode_select_ff;
    logic [7:0]   deadband_setting_ff;
    logic [11:0]  report_period_setting_ff;
    logic [7:0]   cold_threshold_ff;
    logic [7:0]   hot_threshold_ff;
    logic [7:0]   range_floor_ff;
    logic [7:0]   range_ceiling_ff;
    logic [2:0]   irq_stat_ff;
    logic [2:0]   irq_mask_ff;
    logic         rpt_irq_ff;
    logic         rpt_mask_ff;
    logic [7:0]   temp_ff;
    logic [7:0]   ref_ff;
    logic signed [31:0] accum_ff; // R13

    wire wr_mode     = wr_in && (addr_in == A_MODE);
    wire wr_deadband = wr_in && (addr_in == A_DEADBAND);
    wire wr_period   = wr_in && (addr_in == A_PERIOD);
    wire wr_cold     = wr_in && (addr_in == A_COLD);
    wire wr_hot      = wr_in && (addr_in == A_HOT);
    wire wr_floor    = wr_in && (addr_in == A_FLOOR);
    wire wr_ceiling  = wr_in && (addr_in == A_CEILING);
    wire wr_istat    = wr_in && (addr_in == A_IRQ_STAT);
    wire wr_imask    = wr_in && (addr_in == A_IRQ_MASK);

    wire [7:0] nxt_deadband =
        clamp8(wdata_in[7:0], `DEADBAND_MIN, `DEADBAND_MAX); // R2
    wire [11:0] nxt_period = (wdata_in > 16'(`PERIOD_MAX)) ?
        `PERIOD_MAX : wdata_in[11:0]; // R5
    wire report_mode_t nxt_mode = (wdata_in[1:0] == 2'h3) ?
        MODE_OFF : report_mode_t'(wdata_in[1:0]);

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            report_mode_select_ff    <= MODE_OFF;
            deadband_setting_ff      <= `DEADBAND_RST;
            report_period_setting_ff <= `PERIOD_RST;
            cold_threshold_ff        <= `COLD_RST;
            hot_threshold_ff         <= `HOT_RST;
            range_floor_ff           <= `FLOOR_RST;
            range_ceiling_ff         <= `CEILING_RST;
            irq_mask_ff              <= 3'h0;
            rpt_mask_ff              <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (wr_mode)
                report_mode_select_ff <= nxt_mode; // R12
            if (wr_deadband)
                deadband_setting_ff <= nxt_deadband; // R2
            if (wr_period)
                report_period_setting_ff <= nxt_period; // R5
            if (wr_cold)
                cold_threshold_ff <= clamp_temp(wdata_in);
            if (wr_hot)
                hot_threshold_ff <= clamp_temp(wdata_in);
            if (wr_floor)
                range_floor_ff <= clamp_temp(wdata_in);
            if (wr_ceiling)
                range_ceiling_ff <= clamp_temp(wdata_in);
            if (wr_imask)
            begin
                irq_mask_ff <= wdata_in[2:0];
                rpt_mask_ff <= wdata_in[3];
            end
        end
    end

    // ---------------------------------------------------------------
    // measurement and flags
    // ---------------------------------------------------------------
    wire signed [31:0] t_now = sx(temp_ff);
    wire cold_now  = t_now < sx(cold_threshold_ff); // R8
    wire hot_now   = t_now > sx(hot_threshold_ff); // R9
    wire range_now = (t_now < sx(range_floor_ff)) ||
                     (t_now > sx(range_ceiling_ff)); // R10

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
            temp_ff <= 8'h00;
        else if (clk_en_in && temp_valid_in)
            temp_ff <= temp_in;
    end

    // ---------------------------------------------------------------
    // report triggers
    // ---------------------------------------------------------------
    logic tick;
    logic period_expire;

    seconds_ticker #(.CYCLES(TICK_CYCLES)) u_ticker
    (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .clk_en_in   (clk_en_in),
        .tick_out    (tick)
    );

    period_timer u_period
    (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .clk_en_in   (clk_en_in),
        .tick_in     (tick),
        .period_in   (report_period_setting_ff),
        .expire_out  (period_expire)
    );

    wire signed [31:0] dev  = t_now - sx(ref_ff);
    wire signed [31:0] db   = 32'(deadband_setting_ff);
    wire signed [31:0] lim  = db * 32'(TICK_CYCLES); // R3
    wire amp_trig = (report_mode_select_ff == MODE_AMPLITUDE) &&
                    ((dev > db) || (dev < -db)); // R1
    wire signed [31:0] acc_next = accum_ff + dev;
    wire int_trig = (report_mode_select_ff == MODE_INTEGRATED) &&
                    ((acc_next > lim) || (acc_next < -lim)); // R3
    wire fire = (report_mode_select_ff != MODE_OFF) &&
                (amp_trig || int_trig || period_expire); // R12 R4

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            ref_ff           <= 8'h00;
            accum_ff         <= 32'sh0;
            report_out       <= 1'b0;
            report_value_out <= 8'h00;
        end
        else if (clk_en_in)
        begin
            report_out <= fire;
            if (fire)
            begin
                ref_ff           <= temp_ff; // R14
                accum_ff         <= 32'sh0; // R14
                report_value_out <= temp_ff;
            end
            else if (report_mode_select_ff == MODE_INTEGRATED)
                accum_ff <= acc_next; // R3
            else
                accum_ff <= 32'sh0;
        end
    end

    // ---------------------------------------------------------------
    // outputs, interrupts and readback
    // ---------------------------------------------------------------
    wire [2:0] ev = {range_now, hot_now, cold_now};
    wire [2:0] flags = {range_violation_flag_out, hot_alarm_flag_out,
                        cold_alarm_flag_out};
    wire [2:0] rise = ev & ~flags;
    wire [2:0] clr3 = wr_istat ? wdata_in[2:0] : 3'h0;
    wire       clr_r = wr_istat && wdata_in[3];

    wire [15:0] rd_mux =
        (addr_in == A_MODE)     ? {14'h0, report_mode_select_ff} :
        (addr_in == A_DEADBAND) ? {8'h0, deadband_setting_ff} :
        (addr_in == A_PERIOD)   ? {4'h0, report_period_setting_ff} :
        (addr_in == A_COLD)     ? {8'h0, cold_threshold_ff} :
        (addr_in == A_HOT)      ? {8'h0, hot_threshold_ff} :
        (addr_in == A_FLOOR)    ? {8'h0, range_floor_ff} :
        (addr_in == A_CEILING)  ? {8'h0, range_ceiling_ff} :
        (addr_in == A_TEMP)     ? {8'h0, temp_ff} :
        (addr_in == A_REFVAL)   ? {8'h0, ref_ff} :
        (addr_in == A_STATUS)   ? {13'h0, flags} :
        (addr_in == A_MASK)     ? {13'h0, irq_mask_ff} :
        (addr_in == A_IRQ_STAT) ? {12'h0, rpt_irq_ff, irq_stat_ff} :
        (addr_in == A_IRQ_MASK) ? {12'h0, rpt_mask_ff, irq_mask_ff} :
                                  16'h0000;

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            cold_alarm_flag_out      <= 1'b0;
            hot_alarm_flag_out       <= 1'b0;
            range_violation_flag_out <= 1'b0;
            display_temp_out         <= 8'h00;
            irq_stat_ff              <= 3'h0;
            rpt_irq_ff               <= 1'b0;
            irq_out                  <= 1'b0;
            rdata_out                <= 16'h0000;
        end
        else if (clk_en_in)
        begin
            cold_alarm_flag_out      <= cold_now; // R8
            hot_alarm_flag_out       <= hot_now; // R9
            range_violation_flag_out <= range_now; // R10
            display_temp_out         <= temp_ff; // R7
            irq_stat_ff              <= (irq_stat_ff & ~clr3) | rise;
            rpt_irq_ff               <= (rpt_irq_ff & ~clr_r) | fire;
            irq_out <= |(irq_stat_ff & irq_mask_ff) | (rpt_irq_ff & rpt_mask_ff);
            rdata_out <= rd_in ? rd_mux : 16'h0000;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_cold;
        @(posedge core_clk_in) disable iff (reset_in)
        clk_en_in |=> (cold_alarm_flag_out == $past(cold_now));
    endproperty
    a_cold: assert property (p_cold) else $error("cold flag wrong"); // R8

    property p_hot;
        @(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && (t_now > sx(hot_threshold_ff)) |=> hot_alarm_flag_out;
    endproperty
    a_hot: assert property (p_hot) else $error("hot flag wrong"); // R9

    property p_range;
        @(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && (t_now >= sx(range_floor_ff)) &&
        (t_now <= sx(range_ceiling_ff)) |=> !range_violation_flag_out;
    endproperty
    a_range: assert property (p_range) else $error("range flag wrong"); // R10

    property p_off;
        @(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && (report_mode_select_ff == MODE_OFF) |=> !report_out;
    endproperty
    a_off: assert property (p_off) else $error("report while off"); // R12

    property p_amp;
        @(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && (report_mode_select_ff == MODE_AMPLITUDE) &&
        (dev > db) |=> report_out && (report_value_out == $past(temp_ff));
    endproperty
    a_amp: assert property (p_amp) else $error("amplitude miss"); // R1

    property p_int;
        @(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && (report_mode_select_ff == MODE_INTEGRATED) &&
        ((acc_next > lim) || (acc_next < -lim)) |=> report_out;
    endproperty
    a_int: assert property (p_int) else $error("integrated miss"); // R3

    property p_latch;
        @(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && fire |=> (ref_ff == $past(temp_ff)) && (accum_ff == 0);
    endproperty
    a_latch: assert property (p_latch) else $error("no reference latch"); // R14

    property p_db;
        @(posedge core_clk_in) disable iff (reset_in)
        (deadband_setting_ff >= `DEADBAND_MIN) &&
        (deadband_setting_ff <= `DEADBAND_MAX);
    endproperty
    a_db: assert property (p_db) else $error("deadband out of range"); // R2

    property p_per_max;
        @(posedge core_clk_in) disable iff (reset_in)
        report_period_setting_ff <= `PERIOD_MAX;
    endproperty
    a_per_max: assert property (p_per_max) else $error("period too large"); // R5

    // expiry flop reflects the period of the previous running cycle
    property p_per;
        @(posedge core_clk_in) disable iff (reset_in)
        ($past(clk_en_in) && ($past(report_period_setting_ff) == 12'h000))
        -> !period_expire;
    endproperty
    a_per: assert property (p_per) else $error("period fault"); // R6

    c_amp: cover property (@(posedge core_clk_in) amp_trig ##1 report_out);
    c_int: cover property (@(posedge core_clk_in) int_trig ##1 report_out);
    c_per: cover property (@(posedge core_clk_in) period_expire && fire);
    c_irq: cover property (@(posedge core_clk_in) irq_out);
endmodule // temperature_channel_block

/* report_sink.sv */
`timescale 1ns/1ps
// ----------------------------------------
// supervisory side: collects issued reports
// ----------------------------------------
module report_sink
(
    input  wire logic       core_clk_in,
    input  wire logic       reset_in,
    input  wire logic       report_in,
    input  wire logic [7:0] value_in,
    output int              count_out,
    output logic      [7:0] last_out
);
    initial count_out = 0;
    initial last_out = 8'h00;

    // one report per pulse cycle, value taken with it
    always @(posedge core_clk_in)
    begin
        if (!reset_in && report_in === 1'b1)
        begin
            count_out <= count_out + 1;
            last_out  <= value_in;
        end
    end
endmodule // report_sink

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import temp_report_pkg::*;
    localparam int TICKS = 20;
    logic        core_clk = 1'b0;
    logic        reset    = 1'b1;
    logic        clk_en   = 1'b1;
    logic        tvalid   = 1'b0;
    logic        wr       = 1'b0;
    logic        rd       = 1'b0;
    logic [7:0]  temp     = 8'h00;
    logic [7:0]  addr     = 8'h00;
    logic [15:0] wdata    = 16'h0000;
    logic [15:0] rdata;
    logic        cold, hot, range_v, report, irq;
    logic [7:0]  rep_val, disp, last;
    int          count, base, cyc = 0;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          seed = 32'h2acb3fd6;
    int          cold_t = 50, hot_t = 100, floor_t = 50, ceil_t = 150;
    int          ref_v = 0, n_rep = 0, db = 1;
    logic [7:0]  reg_a [8] = '{8'h00, 8'h04, 8'h08, 8'h0c,
                               8'h10, 8'h14, 8'h18, 8'h3c};
    logic [15:0] reg_e [8] = '{16'h0000, 16'h0001, 16'h0000, 16'h0032,
                               16'h0064, 16'h0032, 16'h0096, 16'h0000};
    logic [7:0]  cl_a [5] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h00};
    logic [15:0] cl_d [5] = '{16'h0000, 16'h0033, 16'h0fa0, 16'h0000, 16'h0003};
    logic [15:0] cl_e [5] = '{16'h0001, 16'h0032, 16'h0e10, 16'h0000, 16'h0000};
    int          amp_t [10] = '{5, 6, 11, 0, -5, -6, -50, 150, 145, 139};
    int          int_d [3] = '{3, -4, 2};

    always #12.5 core_clk = ~core_clk;

    temperature_channel_block #(.TICK_CYCLES(TICKS)) dut_u
    (
        .core_clk_in              (core_clk),
        .reset_in                 (reset),
        .clk_en_in                (clk_en),
        .temp_in                  (temp),
        .temp_valid_in            (tvalid),
        .addr_in                  (addr),
        .wdata_in                 (wdata),
        .wr_in                    (wr),
        .rd_in                    (rd),
        .rdata_out                (rdata),
        .cold_alarm_flag_out      (cold),
        .hot_alarm_flag_out       (hot),
        .range_violation_flag_out (range_v),
        .report_out               (report),
        .report_value_out         (rep_val),
        .display_temp_out         (disp),
        .irq_out                  (irq)
    );

    report_sink sink_u
    (
        .core_clk_in (core_clk),
        .reset_in    (reset),
        .report_in   (report),
        .value_in    (rep_val),
        .count_out   (count),
        .last_out    (last)
    );

    // ----------------------------------------
    // bus, stimulus and compare tasks
    // ----------------------------------------
    task automatic results();
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [15:0] e);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask

    function automatic int rnd_t();
        int r;
        r = $random(seed) % 201;
        if (r < 0)
            r += 201;
        return r - 50;
    endfunction

    task automatic set_temp(input int v);
        @(posedge core_clk);
        temp   <= v[7:0];
        tvalid <= 1'b1;
        @(posedge core_clk);
        tvalid <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("display", {8'h00, v[7:0]}, {8'h00, disp});
        chk("cold", {15'h0000, v < cold_t}, {15'h0000, cold});
        chk("hot", {15'h0000, v > hot_t}, {15'h0000, hot});
        chk("range", {15'h0000, v < floor_t || v > ceil_t},
            {15'h0000, range_v});
    endtask

    task automatic rep_chk();
        chk("report_count", n_rep[15:0], count[15:0]);
        chk("report_value", {8'h00, ref_v[7:0]}, {8'h00, last});
    endtask

    task automatic amp_step(input int v);
        set_temp(v);
        if (v > ref_v + db || v < ref_v - db)
        begin
            ref_v = v;
            n_rep++;
        end
        repeat (2) @(posedge core_clk);
        #1;
        rep_chk();
    endtask

    task automatic window(input int inc);
        repeat (5) @(posedge core_clk);
        #1;
        base = count;
        repeat (120) @(posedge core_clk);
        #1;
        chk("periodic", 16'(base + inc), count[15:0]);
        chk("periodic_value", {8'h00, ref_v[7:0]}, {8'h00, last});
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            results();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd_chk("reset_reg", reg_a[i], reg_e[i]);
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(cl_a[i], cl_d[i]);
            rd_chk("clamp_reg", cl_a[i], cl_e[i]);
        end
        // interrupt: raise, clear, mask
        wr_reg(8'h30, 16'h0001);
        set_temp(60);
        wr_reg(8'h2c, 16'h000f);
        set_temp(10);
        repeat (2) @(posedge core_clk);
        #1;
        chk("irq_set", 16'h0001, {15'h0000, irq});
        rd_chk("irq_status", 8'h2c, 16'h0005);
        set_temp(60);
        wr_reg(8'h2c, 16'h000f);
        repeat (2) @(posedge core_clk);
        #1;
        chk("irq_clear", 16'h0000, {15'h0000, irq});
        wr_reg(8'h30, 16'h0000);
        set_temp(10);
        repeat (2) @(posedge core_clk);
        #1;
        chk("irq_masked", 16'h0000, {15'h0000, irq});
        rd_chk("irq_status", 8'h2c, 16'h0005);
        wr_reg(8'h2c, 16'h000f);
        // random thresholds and temperatures
        for (int i = 0; i < 40; i++)
        begin
            cold_t  = rnd_t();
            hot_t   = rnd_t();
            floor_t = rnd_t();
            ceil_t  = rnd_t();
            wr_reg(8'h0c, 16'(cold_t));
            wr_reg(8'h10, 16'(hot_t));
            wr_reg(8'h14, 16'(floor_t));
            wr_reg(8'h18, 16'(ceil_t));
            set_temp(rnd_t());
        end
        // amplitude mode
        rd_chk("reference", 8'h20, 16'h0000);
        set_temp(0);
        db = 5;
        wr_reg(8'h04, 16'h0005);
        wr_reg(8'h00, 16'h0001);
        foreach (amp_t[i])
            amp_step(amp_t[i]);
        for (int i = 0; i < 30; i++)
            amp_step(rnd_t());
        amp_step(ref_v > 100 ? ref_v - 20 : ref_v + 20);
        rd_chk("reference", 8'h20, {8'h00, ref_v[7:0]});
        // integrated mode
        db = 1;
        wr_reg(8'h04, 16'h0001);
        wr_reg(8'h00, 16'h0002);
        foreach (int_d[i])
        begin
            set_temp(ref_v + int_d[i]);
            rep_chk();
            repeat (15) @(posedge core_clk);
            #1;
            ref_v += int_d[i];
            n_rep++;
            rep_chk();
        end
        // periodic reporting
        wr_reg(8'h00, 16'h0001);
        wr_reg(8'h08, 16'h0002);
        window(3);
        wr_reg(8'h08, 16'h0000);
        window(0);
        wr_reg(8'h00, 16'h0000);
        wr_reg(8'h08, 16'h0001);
        window(0);
        // frozen block ignores a write
        @(posedge core_clk);
        clk_en <= 1'b0;
        wr_reg(8'h04, 16'h0007);
        @(posedge core_clk);
        clk_en <= 1'b1;
        rd_chk("freeze", 8'h04, 16'h0001);
        results();
    end
endmodule // tb_top
